// ---- core/keypad_pkg.sv ----
// Contract
// - Exactly one of the four row lines is low and the other three are high.
// - Each row is driven low in turn so every row is exercised once a cycle; the code holds the host's pattern and steps one row only on an invalid one.
// - The row pattern holds between frames and changes only on the last rising serial clock of a selected frame.
// - All eight columns are sampled while a row is low to locate a key.
// - Each transfer returns the column response on the master-in data line.
// - The scanner answers only while the keypad chip select is asserted.
// - Two quadrature phases and the push switch are passed on to the host.
package keypad_pkg;

    // ****************************************
    // Matrix shape and reset values
    // ****************************************
    localparam int         ROWS          = 4;
    localparam int         COLS          = 8;
    localparam logic [3:0] ROW_RESET     = 4'hE;
    localparam logic [7:0] COL_IDLE      = 8'hFF;
    localparam logic [2:0] BIT_CNT_RESET = 3'h0;
    localparam logic [2:0] BIT_LAST      = 3'h7;

    // Synchronised pin group.
    typedef struct packed {
        logic       sclk;
        logic       cs_n;
        logic       mosi;
        logic [7:0] col;
        logic       pha;
        logic       phb;
        logic       sw_n;
    } pins_t;

    localparam int PINS_W = $bits(pins_t);

endpackage

// ---- core/sync2.sv ----
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    // Data.
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta;
    logic [W-1:0] stage;

    // Two flip-flop synchroniser; the first stage feeds only the second.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta  <= '1;
            stage <= '1;
        end else begin
            meta  <= d_i;
            stage <= meta;
        end
    end

    assign q_o = stage;

endmodule

// ---- core/keypad_scanner.sv ----
`timescale 1ns/1ps
module keypad_scanner (
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // Serial port from the host.
    input  wire logic       sclk_i,
    input  wire logic       keypad_chip_select_n_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    output logic            miso_oe_n_o,
    // Keypad matrix.
    output logic [3:0]      row_n_o,
    input  wire logic [7:0] col_n_i,
    // Rotary selector.
    input  wire logic       quadrature_phase_a_i,
    input  wire logic       quadrature_phase_b_i,
    input  wire logic       push_switch_n_i,
    output logic            phase_a_o,
    output logic            phase_b_o,
    output logic            push_switch_n_o
);

    // ****************************************
    // Pin synchronisation
    // ****************************************
    keypad_pkg::pins_t raw;
    keypad_pkg::pins_t pins;

    assign raw = '{sclk: sclk_i, cs_n: keypad_chip_select_n_i, mosi: mosi_i,
                   col: col_n_i, pha: quadrature_phase_a_i,
                   phb: quadrature_phase_b_i, sw_n: push_switch_n_i};

    sync2 #(.W(keypad_pkg::PINS_W)) u_sync (
        .clk_i     (clk_i),
        .nrst_i    (nrst_i),
        .d_i       (raw),
        .q_o       (pins)
    );

    // ****************************************
    // Row pattern decode
    // ****************************************
    // True when exactly one row line of the pattern is low; used by the
    // frame end load and by the checks.
    function automatic logic single_low(input logic [3:0] pat);
        return $countones(~pat) == 1;
    endfunction

    // ****************************************
    // Serial state
    // ****************************************
    // Every pin reaches the logic two clocks late, so the serial clock must
    // stay at each level for at least three clocks to be seen reliably.
    logic       sclk_d;
    logic [3:0] row_shift;
    logic [3:0] row_n;
    logic [7:0] tx;
    logic [2:0] bit_cnt;
    logic [3:0] next_row_shift;
    logic [3:0] next_row_n;
    logic [7:0] next_tx;
    logic [2:0] next_bit_cnt;
    logic       rise;
    logic       fall;
    logic       active;

    assign active = !pins.cs_n;
    assign rise   = active && pins.sclk && !sclk_d;
    assign fall   = active && !pins.sclk && sclk_d;

    // Next values: shift in the row pattern, shift out column response.
    always_comb begin
        next_row_shift = row_shift;
        next_row_n     = row_n;
        next_tx        = tx;
        next_bit_cnt   = bit_cnt;
        if (!active) begin
            next_bit_cnt = keypad_pkg::BIT_CNT_RESET;
            next_tx      = pins.col;
        end else begin
            if (rise) begin
                next_row_shift = {row_shift[2:0], pins.mosi};
                next_bit_cnt   = bit_cnt + 3'h1;
            end
            if (fall) begin
                next_tx = {tx[6:0], 1'b1};
            end
        end
        if (rise && bit_cnt == keypad_pkg::BIT_LAST) begin
            if (single_low(next_row_shift)) begin
                next_row_n = next_row_shift;
            end else begin
                next_row_n = {row_n[2:0], row_n[3]};
            end
        end
    end

    // Register the serial state; the row pattern keeps its last value.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sclk_d    <= 1'b0;
            row_shift <= keypad_pkg::ROW_RESET;
            row_n     <= keypad_pkg::ROW_RESET;
            tx        <= keypad_pkg::COL_IDLE;
            bit_cnt   <= keypad_pkg::BIT_CNT_RESET;
        end else begin
            sclk_d    <= pins.sclk;
            row_shift <= next_row_shift;
            row_n     <= next_row_n;
            tx        <= next_tx;
            bit_cnt   <= next_bit_cnt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // row pattern, held between frames
    assign row_n_o     = row_n;
    assign miso_o      = tx[7];
    assign miso_oe_n_o = pins.cs_n;

    assign phase_a_o       = pins.pha;
    assign phase_b_o       = pins.phb;
    assign push_switch_n_o = pins.sw_n;

    // ****************************************
    // Checks
    // ****************************************
    // Most properties watch the synchronised pins; those on raw pins
    // allow for the two flip-flop delay of the synchroniser.

    // The last rising serial clock edge of a frame.
    sequence frame_bit;
        rise && bit_cnt == keypad_pkg::BIT_LAST;
    endsequence

    // The synchronised select has just gone low.
    sequence select_fell;
        $fell(pins.cs_n);
    endsequence

    one_row_low_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        single_low(row_n))
        else $error("row pattern not single low");

    row_moves_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !(rise && bit_cnt == keypad_pkg::BIT_LAST) |=> $stable(row_n))
        else $error("row changed outside a frame end");

    row_load_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        frame_bit ##0 single_low(next_row_shift)
            |=> row_n == $past(next_row_shift))
        else $error("valid row pattern not loaded");

    row_rotate_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        frame_bit ##0 !single_low(next_row_shift)
            |=> row_n == {$past(row_n[2:0]), $past(row_n[3])})
        else $error("invalid row pattern did not rotate");

    // The enable follows the select pin through the two flip-flops.
    idle_miso_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        $past(keypad_chip_select_n_i, 2) |-> miso_oe_n_o)
        else $error("miso driven without select");

    count_clear_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        pins.cs_n |=> bit_cnt == keypad_pkg::BIT_CNT_RESET)
        else $error("bit count kept without select");

    row_shift_hold_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !active |=> $stable(row_shift))
        else $error("pattern shifted without select");

    first_bit_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        select_fell |-> miso_o == $past(pins.col[7]))
        else $error("first response bit not column seven");

    col_load_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        pins.cs_n |=> tx == $past(pins.col))
        else $error("column sample not loaded");

    tx_shift_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        fall |=> tx == {$past(tx[6:0]), 1'b1})
        else $error("response not shifted");

    miso_hold_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (active && !fall) |=> $stable(tx))
        else $error("response changed between falls");

    no_key_high_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (pins.cs_n && pins.col == keypad_pkg::COL_IDLE)
            |=> miso_o)
        else $error("idle column not high");

    // Each rotary output repeats its pin two clocks later.
    rotary_pass_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        $past(nrst_i, 2) && $past(nrst_i)
            |-> phase_a_o == $past(quadrature_phase_a_i, 2)
            && phase_b_o == $past(quadrature_phase_b_i, 2)
            && push_switch_n_o == $past(push_switch_n_i, 2))
        else $error("rotary not passed");

    bit_count_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        rise |=> bit_cnt == $past(bit_cnt) + 3'h1)
        else $error("bit count slip");

endmodule

// ---- verification/spi_host_model.sv ----
`timescale 1ns/1ps
// ********
// Host side of the serial port.
// ********
module spi_host_model (
    // Clock.
    input  wire logic clk_i,
    // Serial port.
    output logic      sclk_o = 1'b0,
    output logic      cs_n_o = 1'b1,
    output logic      mosi_o = 1'b0,
    input  wire logic miso_i
);
    // One mode 0 byte, MSB first, with the reply taken at each rise.
    task automatic xfer(input logic [7:0] tx, input logic sel,
                        output logic [7:0] rx);
        cs_n_o <= ~sel;
        for (int i = 7; i >= 0; i--) begin
            mosi_o <= tx[i];
            repeat (8) @(posedge clk_i);
            sclk_o <= 1'b1;
            rx[i] = miso_i;
            repeat (8) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        // The released data line shows the inverse of its last bit.
        repeat (8) @(posedge clk_i);
        cs_n_o <= 1'b1;
        mosi_o <= ~tx[0];
        repeat (8) @(posedge clk_i);
    endtask
endmodule

// ---- verification/front_panel_keypad_scanner_test.sv ----
`timescale 1ns/1ps
// ********
// Keypad scanner bench.
// ********
module front_panel_keypad_scanner_test;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       sclk, cs_n, mosi, miso, oe_n;
    logic [3:0] row_n;
    logic [7:0] col_n = 8'hFF;
    logic [7:0] rx;
    logic [2:0] rot = 3'h7;
    wire  [2:0] rot_o;
    logic [1:0] key_r = 2'h0;
    logic [2:0] key_c = 3'h0;
    int         bad_count = 0;
    int         n_checks = 0;
    int         cyc = 0;

    // Clock of 25 ns period.
    initial forever #12.5 clk = ~clk;

    // One pressed key joins its row to its column.
    always @(posedge clk) begin
        col_n <= row_n[key_r] ? 8'hFF : ~(8'h01 << key_c);
    end

    // Hang guard.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            bad_count++;
            test_done();
        end
    end

    spi_host_model u_host (.clk_i(clk), .sclk_o(sclk), .cs_n_o(cs_n),
        .mosi_o(mosi), .miso_i(miso));

    keypad_scanner u_dut (.clk_i(clk), .nrst_i(nrst), .sclk_i(sclk),
        .keypad_chip_select_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
        .miso_oe_n_o(oe_n), .row_n_o(row_n), .col_n_i(col_n),
        .quadrature_phase_a_i(rot[2]), .quadrature_phase_b_i(rot[1]),
        .push_switch_n_i(rot[0]), .phase_a_o(rot_o[2]),
        .phase_b_o(rot_o[1]), .push_switch_n_o(rot_o[0]));

    // Compares and counts.
    task automatic chk(input string nm, input logic [7:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Walks the zero over the rows and reads every column once.
    task automatic t_scan();
        logic [1:0] prev;
        logic [3:0] pat;
        prev = 2'h0;
        for (int k = 0; k < 8; k++) begin
            pat = ~(4'h1 << k[1:0]);
            key_r <= k[1:0];
            key_c <= k[2:0];
            // Let the new key reach the column snapshot before the frame.
            repeat (4) @(posedge clk);
            u_host.xfer({4'hF, pat}, 1'b1, rx);
            chk("idle", rx, prev == k[1:0] ? ~(8'h01 << k) : 8'hFF);
            chk("row", {4'h0, row_n}, {4'h0, pat});
            u_host.xfer({4'hF, pat}, 1'b1, rx);
            chk("col", rx, ~(8'h01 << k));
            prev = k[1:0];
        end
    endtask

    // A frame with or without select; only a selected one moves the row.
    task automatic t_select(input logic sel);
        logic [3:0] old;
        old = row_n;
        fork
            u_host.xfer(8'hFB, sel, rx);
            begin
                repeat (20) @(posedge clk);
                chk("oe", {7'h0, oe_n}, {7'h0, ~sel});
            end
        join
        chk("sel", {4'h0, row_n}, {4'h0, sel ? 4'hB : old});
    endtask

    // Rotary pins reach the host side.
    task automatic t_rotary();
        for (int v = 0; v < 8; v++) begin
            rot <= v[2:0];
            repeat (6) @(posedge clk);
            chk("rot", {5'h0, rot_o}, {5'h0, v[2:0]});
        end
    endtask

    // A pattern with no low row makes the scan step on by one row.
    task automatic t_bad_pattern();
        u_host.xfer(8'hFF, 1'b1, rx);
        chk("bad_rx", rx, 8'hFF);
        chk("bad_row", {4'h0, row_n}, 8'h07);
    endtask

    // Gray steps in one direction on the phases; the bench, as host, counts each forward step.
    task automatic t_turn();
        logic [1:0] last;
        logic [1:0] g;
        int         fwd;
        fwd = 0;
        rot <= 3'h1;
        repeat (6) @(posedge clk);
        last = rot_o[2:1];
        for (int i = 1; i <= 8; i++) begin
            g = i[1:0] ^ {1'b0, i[1]};
            rot <= {g, 1'b1};
            repeat (6) @(posedge clk);
            if (last[1] ^ rot_o[1]) begin
                fwd++;
            end
            last = rot_o[2:1];
        end
        chk("turn", fwd[7:0], 8'h08);
    endtask

    // Verdict.
    task automatic test_done();
        if (bad_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (20) @(posedge clk);
        chk("rst", {4'h0, row_n}, {4'h0, keypad_pkg::ROW_RESET});
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_scan();
        t_select(1'b0);
        t_select(1'b1);
        t_bad_pattern();
        t_rotary();
        t_turn();
        test_done();
    end
endmodule
